// file: hw/cell_storage_reg.v
`timescale 1ns/1ps
module cell_storage_reg (
    input wire mclk_in,
    input wire rst_in,
    input wire tick_in,
    input wire aclr_in,
    input wire sclr_in,
    input wire sload_in,
    input wire load_d_in,
    input wire d_in,
    output wire q_out
);
    reg q_ff;

    // clear does not wait for a cluster clock edge
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            q_ff <= 1'b0;
        end else if (aclr_in) begin
            q_ff <= 1'b0;
        end else if (tick_in) begin
            if (sclr_in) begin
                q_ff <= 1'b0;
            end else if (sload_in) begin
                q_ff <= load_d_in;
            end else begin
                q_ff <= d_in;
            end
        end
    end

    assign q_out = q_ff;
endmodule // cell_storage_reg

// file: hw/cluster_map.vh
`ifndef CLUSTER_MAP_VH
`define CLUSTER_MAP_VH

// bus register word indices, byte address bits [7:2]
`define ADR_LUT_TOP_LO 6'h00
`define ADR_LUT_TOP_HI 6'h01
`define ADR_LUT_BOT_LO 6'h02
`define ADR_LUT_BOT_HI 6'h03
`define ADR_CELL_CFG 6'h04
`define ADR_REG_CFG 6'h05
`define ADR_CLU_CFG 6'h06
`define ADR_STATUS 6'h07

`define RST_WORD 32'h00000000
`define CELL_CFG_MASK 32'h000001FF
`define REG_CFG_MASK 32'h0FFFFFFF
`define CLU_CFG_MASK 32'h00007FFF

// cell configuration fields
`define CC_OUT_TOP_LSB 0
`define CC_OUT_BOT_LSB 3
`define CC_SAME_FN 6
`define CC_FB_TOP 7
`define CC_FB_BOT 8

// per storage register fields, RF_W bits each in reg_cfg
`define RF_W 7
`define RF_CLK_LSB 0
`define RF_ACLR_LSB 2
`define RF_SCLR 4
`define RF_SLOAD 5
`define RF_SRC 6

// cluster configuration fields
`define CL_SRC0_LSB 0
`define CL_SRC1_LSB 3
`define CL_PICK_LSB 6
`define CL_CLR0_LSB 9
`define CL_CLR1_LSB 12

// local control input bits
`define LC_CLR_SRC_LSB 0
`define LC_ENA_LSB 2
`define LC_SCLR 5
`define LC_SLOAD 6

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: hw/combinational_lut_half.v
`timescale 1ns/1ps
module combinational_lut_half #(
    parameter IN_W = 6
) (
    input wire [(1<<IN_W)-1:0] mask_in,
    input wire [IN_W-1:0] sel_in,
    output wire f_out
);
    // truth table lookup
    assign f_out = mask_in[sel_in];
endmodule // combinational_lut_half

// file: hw/logic_cluster.v
// Contract
// - two clock sources and three enables form three cluster clocks, each tied to its enable.
// - an inactive enable stops its cluster clock so registers on it hold.
// - cluster control comes from the six row clocks and the local control inputs.
// - storage registers clear asynchronously from at most two cluster clears.
// - the active-low chip-wide clear resets every storage, clock, synchroniser and output register above all other controls; configuration is kept.
// - the cell holds two lut halves over eight inputs and four registers.
// - each register has data, clock, synchronous clear, asynchronous clear and load.
// - combinational use bypasses the registers to the outputs.
// - one output may carry a lut result while another carries a register.
// - a register output can feed back into the lut of the same cell.
// - normal mode gives two functions or one of six inputs from eight data inputs.
// - two five-input functions share the first two inputs, a four and five share one.
// - two six-input functions pack only with four shared inputs and one function; the code also packs two separate tables while CC_SAME_FN is clear.
// - the top input pair serves the top register and outputs, the bottom pair the bottom.
// - with the top pair in use the bottom pair packs a register; its last input only if unregistered.
// - two outputs drive routing and one of them also drives local interconnect.
`timescale 1ns/1ps
`include "cluster_map.vh"
module logic_cluster #(
    parameter ROW_W = 6,
    parameter LOCAL_W = 7,
    parameter NCLK = 3
) (
    input wire mclk_in,
    input wire rst_in,
    input wire chip_wide_clear_n_in,
    input wire [7:0] awaddr_in,
    input wire awvalid_in,
    output wire awready_out,
    input wire [31:0] wdata_in,
    input wire [3:0] wstrb_in,
    input wire wvalid_in,
    output wire wready_out,
    output wire [1:0] bresp_out,
    output wire bvalid_out,
    input wire bready_in,
    input wire [7:0] araddr_in,
    input wire arvalid_in,
    output wire arready_out,
    output wire [31:0] rdata_out,
    output wire [1:0] rresp_out,
    output wire rvalid_out,
    input wire rready_in,
    input wire [ROW_W-1:0] row_clk_in,
    input wire [LOCAL_W-1:0] local_ctrl_in,
    input wire [3:0] lut_in_abcd_in,
    input wire lut_in_e_top_in,
    input wire lut_in_f_top_in,
    input wire lut_in_e_bottom_in,
    input wire lut_in_f_bottom_in,
    output wire [NCLK-1:0] cluster_clk_out,
    output wire route_top_out,
    output wire route_bottom_out,
    output wire local_drive_out
);
    localparam SYNC_W = ROW_W + LOCAL_W + 8;

    // chip-wide clear joins reset for the synchroniser, clock, storage and output registers
    wire arst;
    assign arst = rst_in | ~chip_wide_clear_n_in;

    // pin synchronisers: a change counts when stages two and three agree
    wire [SYNC_W-1:0] pin_raw;
    reg [SYNC_W-1:0] sync1_ff;
    reg [SYNC_W-1:0] sync2_ff;
    reg [SYNC_W-1:0] sync3_ff;
    reg [SYNC_W-1:0] pin_ff;
    wire [SYNC_W-1:0] agree;

    assign pin_raw = {row_clk_in, local_ctrl_in, lut_in_f_bottom_in, lut_in_e_bottom_in,
                      lut_in_f_top_in, lut_in_e_top_in, lut_in_abcd_in};
    assign agree = ~(sync2_ff ^ sync3_ff);

    always @(posedge mclk_in or posedge arst) begin
        if (arst) begin
            sync1_ff <= {SYNC_W{1'b0}};
            sync2_ff <= {SYNC_W{1'b0}};
            sync3_ff <= {SYNC_W{1'b0}};
            pin_ff <= {SYNC_W{1'b0}};
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pin_ff <= (agree & sync3_ff) | (~agree & pin_ff);
        end
    end

    wire [3:0] in_abcd;
    wire in_e_top;
    wire in_f_top;
    wire in_e_bot;
    wire in_f_bot;
    wire [LOCAL_W-1:0] lctl;
    wire [ROW_W-1:0] rowc;
    assign in_abcd = pin_ff[3:0];
    assign in_e_top = pin_ff[4];
    assign in_f_top = pin_ff[5];
    assign in_e_bot = pin_ff[6];
    assign in_f_bot = pin_ff[7];
    assign lctl = pin_ff[8 +: LOCAL_W];
    assign rowc = pin_ff[8 + LOCAL_W +: ROW_W];

    // configuration registers
    reg [31:0] lut_top_lo_ff;
    reg [31:0] lut_top_hi_ff;
    reg [31:0] lut_bot_lo_ff;
    reg [31:0] lut_bot_hi_ff;
    reg [31:0] cell_cfg_ff;
    reg [31:0] reg_cfg_ff;
    reg [31:0] clu_cfg_ff;

    // cluster clock sources and clears picked from row clocks and local lines
    wire [7:0] row_pad;
    wire [7:0] clr_vec;
    wire [1:0] src_lvl;
    wire [1:0] clr_lvl;
    assign row_pad = {{(8-ROW_W){1'b0}}, rowc};
    assign clr_vec = {lctl[`LC_CLR_SRC_LSB +: 2], rowc};
    assign src_lvl[0] = row_pad[clu_cfg_ff[`CL_SRC0_LSB +: 3]];
    assign src_lvl[1] = row_pad[clu_cfg_ff[`CL_SRC1_LSB +: 3]];
    assign clr_lvl[0] = clr_vec[clu_cfg_ff[`CL_CLR0_LSB +: 3]];
    assign clr_lvl[1] = clr_vec[clu_cfg_ff[`CL_CLR1_LSB +: 3]];

    reg [NCLK-1:0] en_lat_ff;
    reg [NCLK-1:0] cclk_ff;
    reg [NCLK-1:0] cclk_prev_ff;
    wire [NCLK-1:0] tick;

    genvar k;
    generate
        for (k = 0; k < NCLK; k = k + 1) begin : g_cclk
            wire lvl;
            assign lvl = src_lvl[clu_cfg_ff[`CL_PICK_LSB + k]];
            // enable is taken only while the source is low, so no runt pulse
            always @(posedge mclk_in or posedge arst) begin
                if (arst) begin
                    en_lat_ff[k] <= 1'b0;
                    cclk_ff[k] <= 1'b0;
                    cclk_prev_ff[k] <= 1'b0;
                end else begin
                    if (!lvl) begin
                        en_lat_ff[k] <= lctl[`LC_ENA_LSB + k];
                    end
                    cclk_ff[k] <= lvl & en_lat_ff[k];
                    cclk_prev_ff[k] <= cclk_ff[k];
                end
            end
            assign tick[k] = cclk_ff[k] & ~cclk_prev_ff[k];
        end
    endgenerate

    assign cluster_clk_out = cclk_ff;

    // lut halves share inputs a..d; each half owns its e/f pair
    wire [3:0] q;
    wire [63:0] mask_top;
    wire [63:0] mask_bot;
    wire [5:0] sel_top;
    wire [5:0] sel_bot;
    wire lut_top;
    wire lut_bot;
    wire d_top;
    wire d_bot;

    assign d_top = cell_cfg_ff[`CC_FB_TOP] ? q[0] : in_abcd[3];
    assign d_bot = cell_cfg_ff[`CC_FB_BOT] ? q[1] : in_abcd[3];
    assign sel_top = {in_f_top, in_e_top, d_top, in_abcd[2:0]};
    assign sel_bot = {in_f_bot, in_e_bot, d_bot, in_abcd[2:0]};
    assign mask_top = {lut_top_hi_ff, lut_top_lo_ff};
    // CC_SAME_FN makes both halves use the top truth table
    assign mask_bot = cell_cfg_ff[`CC_SAME_FN] ? mask_top :
                      {lut_bot_hi_ff, lut_bot_lo_ff};

    combinational_lut_half #(
        .IN_W(6)
    ) u_lut_top (
        .mask_in(mask_top),
        .sel_in(sel_top),
        .f_out(lut_top)
    );

    combinational_lut_half #(
        .IN_W(6)
    ) u_lut_bot (
        .mask_in(mask_bot),
        .sel_in(sel_bot),
        .f_out(lut_bot)
    );

    // bottom packing through f is refused while a bottom register takes the lut
    wire bot_lut_regd;
    assign bot_lut_regd = ~reg_cfg_ff[`RF_W + `RF_SRC] | ~reg_cfg_ff[3 * `RF_W + `RF_SRC];

    wire [3:0] ticks_pad;
    wire [3:0] clrs_pad;
    wire [3:0] pack_pin;
    assign ticks_pad = {1'b0, tick};
    assign clrs_pad = {1'b0, clr_lvl, 1'b0};
    assign pack_pin = {in_f_bot, in_f_top, in_f_bot, in_e_top};

    genvar r;
    generate
        for (r = 0; r < 4; r = r + 1) begin : g_store
            wire [`RF_W-1:0] f;
            wire lut_d;
            wire pack_ok;
            wire d;
            assign f = reg_cfg_ff[r * `RF_W +: `RF_W];
            assign lut_d = (r % 2 == 0) ? lut_top : lut_bot;
            assign pack_ok = (r % 2 == 0) ? 1'b1 : ~bot_lut_regd;
            assign d = (f[`RF_SRC] && pack_ok) ? pack_pin[r] : lut_d;
            cell_storage_reg u_reg (
                .mclk_in(mclk_in),
                .rst_in(arst),
                .tick_in(ticks_pad[f[`RF_CLK_LSB +: 2]]),
                .aclr_in(clrs_pad[f[`RF_ACLR_LSB +: 2]]),
                .sclr_in(f[`RF_SCLR] & lctl[`LC_SCLR]),
                .sload_in(f[`RF_SLOAD] & lctl[`LC_SLOAD]),
                .load_d_in(in_abcd[2]),
                .d_in(d),
                .q_out(q[r])
            );
        end
    endgenerate

    // output mux: lut results bypass storage, registers may share the outputs
    wire [7:0] out_src;
    reg route_top_ff;
    reg route_bot_ff;
    assign out_src = {2'b00, q, lut_bot, lut_top};

    always @(posedge mclk_in or posedge arst) begin
        if (arst) begin
            route_top_ff <= 1'b0;
            route_bot_ff <= 1'b0;
        end else begin
            route_top_ff <= out_src[cell_cfg_ff[`CC_OUT_TOP_LSB +: 3]];
            route_bot_ff <= out_src[cell_cfg_ff[`CC_OUT_BOT_LSB +: 3]];
        end
    end

    assign route_top_out = route_top_ff;
    assign route_bottom_out = route_bot_ff;
    assign local_drive_out = route_top_ff;

    // register bus slave
    reg aw_held_ff;
    reg w_held_ff;
    reg [5:0] waddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;
    wire do_write;

    assign awready_out = ~aw_held_ff & ~bvalid_ff;
    assign wready_out = ~w_held_ff & ~bvalid_ff;
    assign arready_out = ~rvalid_ff;
    assign bvalid_out = bvalid_ff;
    assign bresp_out = bresp_ff;
    assign rvalid_out = rvalid_ff;
    assign rdata_out = rdata_ff;
    assign rresp_out = rresp_ff;
    assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        input [31:0] keep;
        integer i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
            merge = merge & keep;
        end
    endfunction

    wire wmapped;
    assign wmapped = (waddr_ff <= `ADR_CLU_CFG);

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            waddr_ff <= 6'h00;
            wdata_ff <= `RST_WORD;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
            lut_top_lo_ff <= `RST_WORD;
            lut_top_hi_ff <= `RST_WORD;
            lut_bot_lo_ff <= `RST_WORD;
            lut_bot_hi_ff <= `RST_WORD;
            cell_cfg_ff <= `RST_WORD;
            reg_cfg_ff <= `RST_WORD;
            clu_cfg_ff <= `RST_WORD;
        end else begin
            if (awvalid_in && awready_out) begin
                aw_held_ff <= 1'b1;
                waddr_ff <= awaddr_in[7:2];
            end
            if (wvalid_in && wready_out) begin
                w_held_ff <= 1'b1;
                wdata_ff <= wdata_in;
                wstrb_ff <= wstrb_in;
            end
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wmapped ? `RESP_OKAY : `RESP_SLVERR;
                case (waddr_ff)
                    `ADR_LUT_TOP_LO: lut_top_lo_ff <= merge(lut_top_lo_ff, wdata_ff, wstrb_ff,
                                                            32'hFFFFFFFF);
                    `ADR_LUT_TOP_HI: lut_top_hi_ff <= merge(lut_top_hi_ff, wdata_ff, wstrb_ff,
                                                            32'hFFFFFFFF);
                    `ADR_LUT_BOT_LO: lut_bot_lo_ff <= merge(lut_bot_lo_ff, wdata_ff, wstrb_ff,
                                                            32'hFFFFFFFF);
                    `ADR_LUT_BOT_HI: lut_bot_hi_ff <= merge(lut_bot_hi_ff, wdata_ff, wstrb_ff,
                                                            32'hFFFFFFFF);
                    `ADR_CELL_CFG: cell_cfg_ff <= merge(cell_cfg_ff, wdata_ff, wstrb_ff,
                                                        `CELL_CFG_MASK);
                    `ADR_REG_CFG: reg_cfg_ff <= merge(reg_cfg_ff, wdata_ff, wstrb_ff,
                                                      `REG_CFG_MASK);
                    `ADR_CLU_CFG: clu_cfg_ff <= merge(clu_cfg_ff, wdata_ff, wstrb_ff,
                                                      `CLU_CFG_MASK);
                    default: bresp_ff <= wmapped ? `RESP_OKAY : `RESP_SLVERR;
                endcase
            end else if (bvalid_ff && bready_in) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read side: status shows live cell and clock state
    reg [31:0] rd_mux;
    reg rd_ok;
    always @* begin
        rd_mux = `RST_WORD;
        rd_ok = 1'b1;
        case (araddr_in[7:2])
            `ADR_LUT_TOP_LO: rd_mux = lut_top_lo_ff;
            `ADR_LUT_TOP_HI: rd_mux = lut_top_hi_ff;
            `ADR_LUT_BOT_LO: rd_mux = lut_bot_lo_ff;
            `ADR_LUT_BOT_HI: rd_mux = lut_bot_hi_ff;
            `ADR_CELL_CFG: rd_mux = cell_cfg_ff;
            `ADR_REG_CFG: rd_mux = reg_cfg_ff;
            `ADR_CLU_CFG: rd_mux = clu_cfg_ff;
            `ADR_STATUS: rd_mux = {20'h00000, route_bot_ff, route_top_ff, 1'b0,
                                   cclk_ff, q, lut_bot, lut_top};
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= `RST_WORD;
            rresp_ff <= `RESP_OKAY;
        end else if (arvalid_in && arready_out) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_ff && rready_in) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule // logic_cluster

// file: sim/fabric_model.sv
`timescale 1ns/1ps
module fabric_model (
    input wire mclk_in,
    input wire rst_in,
    input wire run_in,
    input wire [7:0] lut_v_in,
    input wire [6:0] ctl_in,
    output reg [5:0] row_clk_out,
    output reg [6:0] local_ctrl_out,
    output reg [7:0] lut_out
);
    reg [2:0] div_ff;
    // row clock 0 toggles every 8 cycles while run_in, holding its level between bursts
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            div_ff <= 3'h0;
            row_clk_out <= 6'h00;
            local_ctrl_out <= 7'h00;
            lut_out <= 8'h00;
        end else begin
            lut_out <= lut_v_in;
            local_ctrl_out <= ctl_in;
            div_ff <= run_in ? div_ff + 3'h1 : 3'h0;
            if (run_in && div_ff == 3'h7) begin
                row_clk_out[0] <= ~row_clk_out[0];
            end
        end
    end
endmodule // fabric_model

// file: sim/logic_cluster_assertions.sv
`timescale 1ns/1ps
module logic_cluster_assertions #(
    parameter LOCAL_W = 7,
    parameter NCLK = 3
) (
    input wire mclk_in,
    input wire rst_in,
    input wire chip_wide_clear_n_in,
    input wire awvalid_in,
    input wire awready_out,
    input wire wvalid_in,
    input wire wready_out,
    input wire bvalid_out,
    input wire bready_in,
    input wire arvalid_in,
    input wire arready_out,
    input wire [31:0] rdata_out,
    input wire rvalid_out,
    input wire rready_in,
    input wire [LOCAL_W-1:0] local_ctrl_in,
    input wire [NCLK-1:0] cluster_clk_out,
    input wire route_top_out,
    input wire route_bottom_out,
    input wire local_drive_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    a_bresp_holds: assert property (bvalid_out && !bready_in |=> bvalid_out)
        else $error("write response dropped early");
    a_rdata_holds: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
        else $error("read answer changed before taken");
    a_write_answer: assert property (awvalid_in && awready_out && wvalid_in && wready_out
        && !bvalid_out |=> ##1 bvalid_out)
        else $error("write response late");
    a_read_answer: assert property (arvalid_in && arready_out |=> rvalid_out)
        else $error("read answer late");
    a_bus_refusal: assert property ((bvalid_out |-> !awready_out && !wready_out)
        and (rvalid_out |-> !arready_out))
        else $error("request accepted while answer pending");
    a_top_mirror: assert property (local_drive_out == route_top_out)
        else $error("local drive differs from top route");
    a_chip_clear: assert property (!chip_wide_clear_n_in |->
        !route_top_out && !route_bottom_out && cluster_clk_out == {NCLK{1'b0}})
        else $error("outputs not cleared by chip clear");
    a_clk0_gated: assert property (!local_ctrl_in[2] [*8] |-> !$rose(cluster_clk_out[0]))
        else $error("cluster clock 0 ran while disabled");
    a_clk2_gated: assert property (!local_ctrl_in[4] [*8] |-> !$rose(cluster_clk_out[2]))
        else $error("cluster clock 2 not tied to its enable");
endmodule // logic_cluster_assertions
bind logic_cluster logic_cluster_assertions #(.LOCAL_W(LOCAL_W), .NCLK(NCLK)) i_chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .chip_wide_clear_n_in(chip_wide_clear_n_in),
    .awvalid_in(awvalid_in), .awready_out(awready_out), .wvalid_in(wvalid_in),
    .wready_out(wready_out), .bvalid_out(bvalid_out), .bready_in(bready_in),
    .arvalid_in(arvalid_in), .arready_out(arready_out), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .rready_in(rready_in), .local_ctrl_in(local_ctrl_in),
    .cluster_clk_out(cluster_clk_out), .route_top_out(route_top_out),
    .route_bottom_out(route_bottom_out), .local_drive_out(local_drive_out)
);

// file: sim/test_logic_cluster.sv
`timescale 1ns/1ps
`include "cluster_map.vh"
module test_logic_cluster;
    reg mclk_in = 1'b0;
    reg rst_in = 1'b1;
    reg chip_wide_clear_n_in = 1'b1;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00, lut_v = 8'h00, v;
    reg [31:0] wdata = 32'h00000000, rd, d;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg run = 1'b0;
    reg [3:0] strb = 4'hF;
    reg [6:0] ctl = 7'h00;
    reg [1:0] rsp;
    reg [63:0] m_top, m_bot;
    wire awready, wready, bvalid, arready, rvalid, rtop, rbot;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [5:0] row;
    wire [6:0] lctl;
    wire [7:0] lut;
    integer fails = 0, total_checks = 0, cyc = 0, i;

    logic_cluster #(.ROW_W(6), .LOCAL_W(7), .NCLK(3)) i_logic_cluster (
        .mclk_in(mclk_in), .rst_in(rst_in), .chip_wide_clear_n_in(chip_wide_clear_n_in),
        .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
        .wdata_in(wdata), .wstrb_in(strb), .wvalid_in(wvalid), .wready_out(wready),
        .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
        .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
        .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
        .row_clk_in(row), .local_ctrl_in(lctl), .lut_in_abcd_in(lut[3:0]),
        .lut_in_e_top_in(lut[4]), .lut_in_f_top_in(lut[5]),
        .lut_in_e_bottom_in(lut[6]), .lut_in_f_bottom_in(lut[7]),
        .cluster_clk_out(), .route_top_out(rtop), .route_bottom_out(rbot),
        .local_drive_out()
    );
    fabric_model i_fabric_model (
        .mclk_in(mclk_in), .rst_in(rst_in), .run_in(run), .lut_v_in(lut_v), .ctl_in(ctl),
        .row_clk_out(row), .local_ctrl_out(lctl), .lut_out(lut)
    );

    initial forever #10 mclk_in = ~mclk_in;
    // hang guard, far above the roughly one thousand cycles the sequence needs
    always @(posedge mclk_in) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            end_of_test;
        end
    end

    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("Error %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // ready raised only once the answer shows, so a held answer is exercised
    task wr(input [7:0] a, input [31:0] dv);
        reg done;
        begin
            done = 1'b0;
            @(posedge mclk_in);
            awaddr <= a;
            wdata <= dv;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            while (!done) begin
                @(posedge mclk_in);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bready && bvalid) begin
                    done = 1'b1;
                    rsp = bresp;
                    bready <= 1'b0;
                end else if (bvalid) bready <= 1'b1;
            end
        end
    endtask
    task rdr(input [7:0] a);
        reg done;
        begin
            done = 1'b0;
            @(posedge mclk_in);
            araddr <= a;
            arvalid <= 1'b1;
            while (!done) begin
                @(posedge mclk_in);
                if (arready) arvalid <= 1'b0;
                if (rready && rvalid) begin
                    done = 1'b1;
                    rd = rdata;
                    rsp = rresp;
                    rready <= 1'b0;
                end else if (rvalid) rready <= 1'b1;
            end
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge mclk_in);
    endtask
    // four rising edges of row clock 0, then still long enough for outputs to land
    task pulse;
        begin
            run <= 1'b1;
            idle(64);
            run <= 1'b0;
            idle(24);
        end
    endtask
    task wr_top(input [31:0] w);
        begin
            wr(8'h00, w);
            wr(8'h04, w);
        end
    endtask
    function [31:0] exp_lut(input [63:0] m, input [7:0] x, input bot);
        exp_lut = {31'h0, m[{bot ? x[7:6] : x[5:4], x[3:0]}]};
    endfunction

    initial begin
        d = $urandom(83);
        idle(12);
        rst_in <= 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            rdr({i[5:0], 2'b00});
            chk("reset word", `RST_WORD, rd);
        end
        rdr(8'h20);
        chk("unmapped read resp", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
        chk("unmapped read data", 32'h00000000, rd);
        wr(8'h1C, 32'hFFFFFFFF);
        chk("status write resp", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
        for (i = 4; i < 7; i = i + 1) begin
            d = $urandom;
            wr({i[5:0], 2'b00}, d);
            rdr({i[5:0], 2'b00});
            chk("cfg readback", d & (i == 4 ? `CELL_CFG_MASK : i == 5 ? `REG_CFG_MASK
                : `CLU_CFG_MASK), rd);
        end
        // only byte one may change; the rest keeps the last random word
        strb <= 4'h2;
        wr(8'h18, 32'hFFFFFFFF);
        strb <= 4'hF;
        rdr(8'h18);
        chk("strobe merge", (d & `CLU_CFG_MASK & 32'hFFFF00FF) | (`CLU_CFG_MASK & 32'h0000FF00),
            rd);
        m_top = {$urandom, $urandom};
        m_bot = {$urandom, $urandom};
        wr(8'h00, m_top[31:0]);
        wr(8'h04, m_top[63:32]);
        wr(8'h08, m_bot[31:0]);
        wr(8'h0C, m_bot[63:32]);
        rdr(8'h0C);
        chk("lut word", m_bot[63:32], rd);
        // odd passes share the top function across both halves
        for (i = 0; i < 8; i = i + 1) begin
            v = $urandom;
            wr(8'h10, {25'h0, i[0], 6'h08});
            lut_v <= v;
            idle(12);
            chk("route top", exp_lut(m_top, v, 1'b0), {31'h0, rtop});
            chk("route bottom", exp_lut(i[0] ? m_top : m_bot, v, 1'b1), {31'h0, rbot});
        end
        wr_top(32'hAAAAAAAA);
        wr(8'h18, 32'h00000C00);
        wr(8'h14, 32'h0060C1B4);
        wr(8'h10, 32'h00000002);
        ctl <= 7'h04;
        lut_v <= 8'h01;
        pulse;
        chk("reg top", 32'h1, {31'h0, rtop});
        lut_v <= 8'h00;
        ctl <= 7'h00;
        pulse;
        chk("held top", 32'h1, {31'h0, rtop});
        chk("bypass bottom", 32'h0, {31'h0, rbot});
        ctl <= 7'h64;
        lut_v <= 8'h05;
        pulse;
        chk("sclr over load", 32'h0, {31'h0, rtop});
        ctl <= 7'h44;
        lut_v <= 8'h04;
        pulse;
        chk("sync load", 32'h1, {31'h0, rtop});
        ctl <= 7'h45;
        pulse;
        chk("aclr over load", 32'h0, {31'h0, rtop});
        ctl <= 7'h04;
        lut_v <= 8'h01;
        pulse;
        wr_top(32'hFF00FF00);
        wr(8'h10, 32'h00000082);
        lut_v <= 8'h00;
        idle(12);
        chk("feedback", 32'h1, {31'h0, rbot});
        rdr(8'h1C);
        chk("status", 32'h00000C05 | {30'h0, m_bot[0], 1'b0}, rd);
        chip_wide_clear_n_in <= 1'b0;
        idle(2);
        chk("chip clear", 32'h0, {31'h0, rtop});
        chip_wide_clear_n_in <= 1'b1;
        idle(12);
        rdr(8'h10);
        chk("cfg kept", 32'h00000082, rd);
        // top register packs pin e while its lut path would give the cleared q0
        wr(8'h14, 32'h0060C1C0);
        ctl <= 7'h04;
        lut_v <= 8'h10;
        pulse;
        chk("packed top", 32'h1, {31'h0, rtop});
        end_of_test;
    end
endmodule // test_logic_cluster
